/* File: logic/spi_quad_pin_mux.sv */
// Pin multiplexer for port 0 slave data and select pins and decoder 1 phase pins.
`timescale 1ns/10ps
module spi_quad_pin_mux #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       link_clk_i,
  input  wire logic       port_e_pin_six_i,
  output logic            port_e_pin_six_o,
  output logic            port_e_pin_six_oe_n_o,
  input  wire logic       port_e_pin_seven_i,
  output logic            port_e_pin_seven_o,
  output logic            port_e_pin_seven_oe_n_o,
  input  wire logic       port_c_pin_zero_i,
  output logic            port_c_pin_zero_o,
  output logic            port_c_pin_zero_oe_n_o,
  input  wire logic       port_c_pin_one_i,
  output logic            port_c_pin_one_o,
  output logic            port_c_pin_one_oe_n_o,
  input  wire logic       config_write_i,
  input  wire logic [3:0] gpio_select_i,
  input  wire logic [3:0] gpio_dir_i,
  input  wire logic [3:0] gpio_data_i,
  input  wire logic [1:0] port_e_pullup_enable_i,
  input  wire logic [1:0] port_c_pullup_enable_i,
  input  wire logic       phase_a_alt_select_i,
  input  wire logic       phase_b_alt_select_i,
  input  wire logic [1:0] timer_select_i,
  input  wire logic       port0_master_mode_i,
  input  wire logic       port1_master_mode_i,
  input  wire logic [1:0] timer_b_out_i,
  input  wire logic [1:0] timer_b_drive_i,
  input  wire logic       port0_slave_data_in_i,
  input  wire logic [7:0] port0_tx_data_i,
  input  wire logic [7:0] port1_tx_data_i,
  input  wire logic       port1_start_i,
  output logic [3:0]      pullup_en_o,
  output logic [3:0]      gpio_in_o,
  output logic            decoder1_phase_a_o,
  output logic            decoder1_phase_b_o,
  output logic            timer_b_channel_zero_o,
  output logic            timer_b_channel_one_o,
  output logic            port0_master_data_in_o,
  output logic            port0_selected_o,
  output logic [7:0]      port0_rx_data_o,
  output logic            port0_rx_valid_o,
  output logic            port1_busy_o,
  output logic [7:0]      port1_rx_data_o,
  output logic            port1_rx_valid_o,
  output logic            port_c_unconfigured_o
);
  localparam int unsigned WB = spi_quad_pin_mux_pkg::WORD_BITS;
  localparam logic [7:0] HALF_CYC = 8'(spi_quad_pin_mux_pkg::PORT1_HALF_CYCLES);

  logic [3:0]    gpio_sel_reg;
  logic [3:0]    gpio_dir_reg;
  logic [3:0]    gpio_data_reg;
  logic [3:0]    pullup_reg;
  logic [1:0]    alt_reg;
  logic [1:0]    timer_sel_reg;
  logic          master0_reg;
  logic          master1_reg;
  logic          unconf_reg;
  logic [3:0]    pin_meta_reg;
  logic [3:0]    pin_sync_reg;
  logic          port1_serial_clock_prev_reg;
  logic [7:0]    tx_hold_reg;
  logic [3:0]    out_reg;
  logic [3:0]    oe_n_reg;
  logic          link_rst_meta_reg;
  logic          link_rst_reg;
  logic [2:0]    tx_cnt_reg;
  logic [7:0]    tx_shift_reg;
  logic          miso_bit_reg;
  logic [2:0]    rx_cnt_reg;
  logic [6:0]    rx_shift_reg;
  logic [7:0]    rx_word_reg;
  logic          rx_toggle_reg;
  logic [2:0]    tog_sync_reg;
  logic [7:0]    div_reg;
  logic          port1_serial_clock_reg;
  logic [4:0]    half_reg;
  logic [7:0]    p1_tx_shift_reg;
  logic          port1_master_data_out_reg;
  logic [7:0]    p1_rx_shift_reg;
  logic [2:0]    p1_rx_cnt_reg;
  logic          e6_link_sel;
  logic          ss_n;

  // Configuration is loaded by a write strobe; reset leaves the serial and decoder functions.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      gpio_sel_reg  <= spi_quad_pin_mux_pkg::GPIO_SELECT_RST;
      gpio_dir_reg  <= spi_quad_pin_mux_pkg::GPIO_DIR_RST;
      gpio_data_reg <= spi_quad_pin_mux_pkg::GPIO_DATA_RST;
      pullup_reg    <= spi_quad_pin_mux_pkg::PULLUP_RST;
      alt_reg       <= spi_quad_pin_mux_pkg::ALT_SELECT_RST;
      timer_sel_reg <= spi_quad_pin_mux_pkg::TIMER_SELECT_RST;
      master0_reg   <= 1'b0;
      master1_reg   <= 1'b0;
      unconf_reg    <= ~FULL_VARIANT;
    end else if (config_write_i) begin
      gpio_sel_reg  <= gpio_select_i;
      gpio_dir_reg  <= gpio_dir_i;
      gpio_data_reg <= gpio_data_i;
      pullup_reg    <= {port_c_pullup_enable_i, port_e_pullup_enable_i};
      alt_reg       <= {phase_b_alt_select_i, phase_a_alt_select_i};
      timer_sel_reg <= timer_select_i;
      master0_reg   <= port0_master_mode_i;
      master1_reg   <= port1_master_mode_i;
      unconf_reg    <= 1'b0;
    end
  end

  // Every pin level passes two flip-flops before core logic reads it.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pin_meta_reg <= 4'hF;
      pin_sync_reg <= 4'hF;
    end else begin
      pin_meta_reg <= {port_c_pin_one_i, port_c_pin_zero_i, port_e_pin_seven_i, port_e_pin_six_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign ss_n = pin_sync_reg[spi_quad_pin_mux_pkg::PIN_E7];

  // Pin inputs are presented to the primary functions and the general-purpose readback.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      gpio_in_o              <= 4'hF;
      decoder1_phase_a_o     <= 1'b1;
      decoder1_phase_b_o     <= 1'b1;
      timer_b_channel_zero_o <= 1'b1;
      timer_b_channel_one_o  <= 1'b1;
      port0_master_data_in_o <= 1'b1;
      port0_selected_o       <= 1'b0;
      pullup_en_o            <= spi_quad_pin_mux_pkg::PULLUP_RST;
      port_c_unconfigured_o  <= ~FULL_VARIANT;
    end else begin
      gpio_in_o              <= pin_sync_reg;
      decoder1_phase_a_o     <= pin_sync_reg[spi_quad_pin_mux_pkg::PIN_C0];
      decoder1_phase_b_o     <= pin_sync_reg[spi_quad_pin_mux_pkg::PIN_C1];
      timer_b_channel_zero_o <= pin_sync_reg[spi_quad_pin_mux_pkg::PIN_C0];
      timer_b_channel_one_o  <= pin_sync_reg[spi_quad_pin_mux_pkg::PIN_C1];
      port0_master_data_in_o <= pin_sync_reg[spi_quad_pin_mux_pkg::PIN_E6];
      port0_selected_o       <= ~master0_reg & ~gpio_sel_reg[1] & ~ss_n;
      pullup_en_o            <= pullup_reg;
      port_c_unconfigured_o  <= unconf_reg;
    end
  end

  // Transmit word is loaded only while the slave is deselected, so it is still during a frame.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tx_hold_reg <= 8'h00;
    end else if (ss_n) begin
      tx_hold_reg <= port0_tx_data_i;
    end
  end

  // Pin drivers: GPIO overrides, then alternate function, then primary function.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      out_reg  <= 4'h0;
      oe_n_reg <= 4'hF;
    end else begin
      for (int i = 0; i < spi_quad_pin_mux_pkg::NUM_PINS; i++) begin
        out_reg[i]  <= gpio_data_reg[i];
        oe_n_reg[i] <= ~gpio_dir_reg[i];
      end
      if (!gpio_sel_reg[0]) begin
        oe_n_reg[0] <= master0_reg | ss_n;
      end
      if (!gpio_sel_reg[1]) begin
        oe_n_reg[1] <= 1'b1;
      end
      if (!gpio_sel_reg[2]) begin
        if (unconf_reg) begin
          oe_n_reg[2] <= 1'b1;
        end else if (alt_reg[0]) begin
          out_reg[2]  <= port1_serial_clock_reg;
          oe_n_reg[2] <= ~master1_reg;
        end else begin
          out_reg[2]  <= timer_b_out_i[0];
          oe_n_reg[2] <= ~(timer_sel_reg[0] & timer_b_drive_i[0]);
        end
      end
      if (!gpio_sel_reg[3]) begin
        if (unconf_reg) begin
          oe_n_reg[3] <= 1'b1;
        end else if (alt_reg[1]) begin
          out_reg[3]  <= port1_master_data_out_reg;
          oe_n_reg[3] <= ~master1_reg;
        end else begin
          out_reg[3]  <= timer_b_out_i[1];
          oe_n_reg[3] <= ~(timer_sel_reg[1] & timer_b_drive_i[1]);
        end
      end
    end
  end

  assign e6_link_sel = ~gpio_sel_reg[0];
  assign port_e_pin_six_o        = e6_link_sel ? miso_bit_reg : out_reg[0];
  assign port_e_pin_six_oe_n_o   = oe_n_reg[0];
  assign port_e_pin_seven_o      = out_reg[1];
  assign port_e_pin_seven_oe_n_o = oe_n_reg[1];
  assign port_c_pin_zero_o       = out_reg[2];
  assign port_c_pin_zero_oe_n_o  = oe_n_reg[2];
  assign port_c_pin_one_o        = out_reg[3];
  assign port_c_pin_one_oe_n_o   = oe_n_reg[3];

  // Link-side reset, synchronised to the port 0 serial clock.
  always_ff @(posedge link_clk_i) begin
    link_rst_meta_reg <= reset_i;
    link_rst_reg      <= link_rst_meta_reg;
  end

  // Slave data leaves on the rising edge, half a period before the master samples on the fall.
  always_ff @(posedge link_clk_i or posedge port_e_pin_seven_i) begin
    if (port_e_pin_seven_i) begin
      tx_cnt_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      miso_bit_reg <= 1'b0;
    end else if (tx_cnt_reg == 3'h0) begin
      miso_bit_reg <= tx_hold_reg[WB-1];
      tx_shift_reg <= {tx_hold_reg[WB-2:0], 1'b0};
      tx_cnt_reg   <= 3'h1;
    end else begin
      miso_bit_reg <= tx_shift_reg[WB-1];
      tx_shift_reg <= {tx_shift_reg[WB-2:0], 1'b0};
      tx_cnt_reg   <= tx_cnt_reg + 3'h1;
    end
  end

  // Slave receive on the falling edge; the frame's select signal clears the bit count.
  always_ff @(negedge link_clk_i or posedge port_e_pin_seven_i) begin
    if (port_e_pin_seven_i) begin
      rx_cnt_reg   <= 3'h0;
      rx_shift_reg <= 7'h00;
    end else begin
      rx_cnt_reg   <= rx_cnt_reg + 3'h1;
      rx_shift_reg <= {rx_shift_reg[5:0], port0_slave_data_in_i};
    end
  end

  // A complete word is parked and announced to the core by a toggle.
  always_ff @(negedge link_clk_i) begin
    if (link_rst_reg) begin
      rx_word_reg   <= 8'h00;
      rx_toggle_reg <= 1'b0;
    end else if (!port_e_pin_seven_i && rx_cnt_reg == 3'h7) begin
      rx_word_reg   <= {rx_shift_reg, port0_slave_data_in_i};
      rx_toggle_reg <= ~rx_toggle_reg;
    end
  end

  // Toggle crossing; the word is stable for a whole byte time after the toggle flips.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tog_sync_reg     <= 3'h0;
      port0_rx_data_o  <= 8'h00;
      port0_rx_valid_o <= 1'b0;
    end else begin
      tog_sync_reg     <= {tog_sync_reg[1:0], rx_toggle_reg};
      port0_rx_valid_o <= (tog_sync_reg[2] ^ tog_sync_reg[1]) & ~master0_reg;
      if (tog_sync_reg[2] ^ tog_sync_reg[1]) begin
        port0_rx_data_o <= rx_word_reg;
      end
    end
  end

  // Port 1 master: divided clock, data changed on the fall, half period before the rise.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      div_reg         <= 8'h00;
      port1_serial_clock_reg       <= 1'b0;
      half_reg        <= 5'h00;
      p1_tx_shift_reg <= 8'h00;
      port1_master_data_out_reg       <= 1'b0;
      port1_busy_o    <= 1'b0;
    end else if (!port1_busy_o) begin
      port1_serial_clock_reg <= 1'b0;
      if (port1_start_i && master1_reg) begin
        port1_master_data_out_reg       <= port1_tx_data_i[WB-1];
        p1_tx_shift_reg <= {port1_tx_data_i[WB-2:0], 1'b0};
        div_reg         <= 8'h00;
        half_reg        <= 5'h00;
        port1_busy_o    <= 1'b1;
      end
    end else if (div_reg == HALF_CYC - 8'h01) begin
      div_reg   <= 8'h00;
      port1_serial_clock_reg <= ~port1_serial_clock_reg;
      half_reg  <= half_reg + 5'h01;
      if (port1_serial_clock_reg) begin
        port1_master_data_out_reg       <= p1_tx_shift_reg[WB-1];
        p1_tx_shift_reg <= {p1_tx_shift_reg[WB-2:0], 1'b0};
      end
      if (half_reg == spi_quad_pin_mux_pkg::PORT1_HALF_COUNT - 5'h01) begin
        port1_busy_o <= 1'b0;
      end
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // Port 1 slave: the phase A pin is the data clock, data is taken on its rising edge.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      port1_serial_clock_prev_reg   <= 1'b0;
      p1_rx_shift_reg  <= 8'h00;
      p1_rx_cnt_reg    <= 3'h0;
      port1_rx_data_o  <= 8'h00;
      port1_rx_valid_o <= 1'b0;
    end else begin
      port1_serial_clock_prev_reg   <= pin_sync_reg[spi_quad_pin_mux_pkg::PIN_C0];
      port1_rx_valid_o <= 1'b0;
      if (!master1_reg && (alt_reg == 2'h3) && (gpio_sel_reg[3:2] == 2'h0)
          && pin_sync_reg[spi_quad_pin_mux_pkg::PIN_C0] && !port1_serial_clock_prev_reg) begin
        p1_rx_shift_reg <= {p1_rx_shift_reg[WB-2:0], pin_sync_reg[spi_quad_pin_mux_pkg::PIN_C1]};
        p1_rx_cnt_reg   <= p1_rx_cnt_reg + 3'h1;
        if (p1_rx_cnt_reg == 3'h7) begin
          port1_rx_data_o  <= {p1_rx_shift_reg[WB-2:0], pin_sync_reg[spi_quad_pin_mux_pkg::PIN_C1]};
          port1_rx_valid_o <= 1'b1;
        end
      end
    end
  end

  // Checks on pin ownership, reset defaults and serial timing.
  sequence cfg_write_s;
    config_write_i;
  endsequence

  unselected_release_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (!gpio_sel_reg[0] && ss_n) |=> port_e_pin_six_oe_n_o)
    else $error("Unselected slave still drives its data pin.");

  master_input_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (!gpio_sel_reg[0] && master0_reg) |=> port_e_pin_six_oe_n_o)
    else $error("Master drives its data input pin.");

  pullup_default_a: assert property (
    @(posedge core_clk_i) $fell(reset_i) |-> pullup_en_o == 4'hF)
    else $error("Pull-ups not enabled after reset.");

  serial_default_a: assert property (
    @(posedge core_clk_i) $fell(reset_i) |-> (gpio_sel_reg == 4'h0) && port_e_pin_seven_oe_n_o)
    else $error("Port E pins not on serial functions after reset.");

  pullup_clear_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    cfg_write_s ##1 !config_write_i |=> pullup_en_o == $past(pullup_reg))
    else $error("Pull-up enable does not follow its configuration.");

  alt_clock_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (alt_reg[0] && !gpio_sel_reg[2] && !unconf_reg && master1_reg)
      |=> port_c_pin_zero_o == $past(port1_serial_clock_reg) && !port_c_pin_zero_oe_n_o)
    else $error("Port 1 clock not routed to phase A pin.");

  alt_data_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (alt_reg[1] && !gpio_sel_reg[3] && !unconf_reg && master1_reg)
      |=> port_c_pin_one_o == $past(port1_master_data_out_reg))
    else $error("Port 1 data not routed to phase B pin.");

  mosi_setup_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(port1_serial_clock_reg) |-> $stable(port1_master_data_out_reg))
    else $error("Port 1 data changed on the sampling edge.");

  gpio_override_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (gpio_sel_reg[2] && !config_write_i) |=> port_c_pin_zero_oe_n_o == ~gpio_dir_reg[2])
    else $error("General-purpose selection did not override the phase A pin.");

  word_length_a: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(port1_busy_o) |-> port1_busy_o [*8])
    else $error("Port 1 word ended too early.");
endmodule : spi_quad_pin_mux

/* File: logic/spi_quad_pin_mux_pkg.sv */
// Constants shared by the serial port and quadrature pin multiplexer.
package spi_quad_pin_mux_pkg;
  // Pin positions inside the four-pin vectors.
  localparam int unsigned PIN_E6 = 0;
  localparam int unsigned PIN_E7 = 1;
  localparam int unsigned PIN_C0 = 2;
  localparam int unsigned PIN_C1 = 3;
  localparam int unsigned NUM_PINS = 4;
  // Reset values of the configuration state.
  localparam logic [3:0] GPIO_SELECT_RST = 4'h0;
  localparam logic [3:0] GPIO_DIR_RST = 4'h0;
  localparam logic [3:0] GPIO_DATA_RST = 4'h0;
  localparam logic [3:0] PULLUP_RST = 4'hF;
  localparam logic [1:0] ALT_SELECT_RST = 2'h0;
  localparam logic [1:0] TIMER_SELECT_RST = 2'h0;
  // Serial word width.
  localparam int unsigned WORD_BITS = 8;
  // Port 1 master serial clock, derived from the 250 MHz core clock.
  localparam int unsigned CORE_PERIOD_PS = 4000;
  localparam int unsigned PORT1_SCLK_PERIOD_NS = 32;
  localparam int unsigned PORT1_HALF_CYCLES =
    (PORT1_SCLK_PERIOD_NS * 1000 / 2) / CORE_PERIOD_PS;
  // Half periods in one word: two per bit.
  localparam logic [4:0] PORT1_HALF_COUNT = 5'h10;
endpackage : spi_quad_pin_mux_pkg

/* File: sim/port0_master_model.sv */
// External serial master model that clocks port 0 of the pin multiplexer as a slave.
`timescale 1ns/10ps
module port0_master_model (
  output logic      link_clk_o,
  output logic      select_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // Idle state: clock still and low, select released to its pull-up level.
  initial begin
    link_clk_o = 1'b0;
    select_n_o = 1'b1;
    mosi_o     = 1'b1;
  end

  // A few clocks with select high, so the slave's link logic sees the reset.
  task automatic reset_clocks(input int n);
    repeat (n) begin
      #3 link_clk_o = 1'b1;
      #3 link_clk_o = 1'b0;
    end
  endtask : reset_clocks

  // One frame of nbits bits, MSB first, at a 6 ns link period.
  task automatic transfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    select_n_o = 1'b0;
    #20.3;
    for (i = 0; i < nbits; i++) begin
      mosi_o = tx[7 - i];
      link_clk_o = 1'b1;
      #3;
      link_clk_o = 1'b0;
      rx = {rx[6:0], miso_i};
      #3;
    end
    select_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released line shows the inverse of its last bit.
  endtask : transfer
endmodule : port0_master_model

/* File: sim/tb.sv */
// Self-checking bench for the serial port and quadrature pin multiplexer.
`timescale 1ns/10ps
module tb;
  // Configuration inputs in port order except timer drive before the master modes, then expected oe_n, driven outputs and pull-ups.
  typedef struct packed {
    logic [23:0] cfg;
    logic [3:0]  exp_oe;
    logic [3:0]  exp_out;
    logic [3:0]  exp_pu;
  } row_t;

  logic       core_clk, reset, config_write, start, alt_a, alt_b, m0, m1;
  logic [3:0] gpio_select, gpio_dir, gpio_data;
  logic [1:0] pe_en, pc_en, tsel, tdrv, tout;
  logic [7:0] tx0, tx1, got, rx_cnt, rx_last, p1_bits;
  wire        link_clk, sel_n, mosi, e6_pin, e7_pin, c0_pin, c1_pin;
  wire        e6_o, e7_o, c0_o, c1_o, e6_oe_n, e7_oe_n, c0_oe_n, c1_oe_n;
  wire        rx0_valid, busy1, unconf;
  wire [3:0]  pullup_en, oe_n, outv;
  wire [7:0]  rx0;
  row_t       rows [7];
  int         failures, compares, cycles, p1_edges, i, k, n;

  // Pin levels: released pins float to their pull-up, select comes from the master.
  assign e6_pin = e6_oe_n ? 1'b1 : e6_o;
  assign e7_pin = e7_oe_n ? sel_n : e7_o;
  assign c0_pin = c0_oe_n ? 1'b1 : c0_o;
  assign c1_pin = c1_oe_n ? 1'b1 : c1_o;
  assign oe_n = {c1_oe_n, c0_oe_n, e7_oe_n, e6_oe_n};
  assign outv = {c1_o, c0_o, e7_o, e6_o};

  spi_quad_pin_mux #(.FULL_VARIANT(1'b1)) spi_quad_pin_mux_inst (
    .core_clk_i(core_clk), .reset_i(reset), .link_clk_i(link_clk),
    .port_e_pin_six_i(e6_pin), .port_e_pin_six_o(e6_o), .port_e_pin_six_oe_n_o(e6_oe_n),
    .port_e_pin_seven_i(e7_pin), .port_e_pin_seven_o(e7_o), .port_e_pin_seven_oe_n_o(e7_oe_n),
    .port_c_pin_zero_i(c0_pin), .port_c_pin_zero_o(c0_o), .port_c_pin_zero_oe_n_o(c0_oe_n),
    .port_c_pin_one_i(c1_pin), .port_c_pin_one_o(c1_o), .port_c_pin_one_oe_n_o(c1_oe_n),
    .config_write_i(config_write), .gpio_select_i(gpio_select), .gpio_dir_i(gpio_dir),
    .gpio_data_i(gpio_data), .port_e_pullup_enable_i(pe_en), .port_c_pullup_enable_i(pc_en),
    .phase_a_alt_select_i(alt_a), .phase_b_alt_select_i(alt_b), .timer_select_i(tsel),
    .port0_master_mode_i(m0), .port1_master_mode_i(m1), .timer_b_out_i(tout),
    .timer_b_drive_i(tdrv), .port0_slave_data_in_i(mosi), .port0_tx_data_i(tx0),
    .port1_tx_data_i(tx1), .port1_start_i(start), .pullup_en_o(pullup_en), .gpio_in_o(),
    .decoder1_phase_a_o(), .decoder1_phase_b_o(), .timer_b_channel_zero_o(),
    .timer_b_channel_one_o(), .port0_master_data_in_o(), .port0_selected_o(),
    .port0_rx_data_o(rx0), .port0_rx_valid_o(rx0_valid), .port1_busy_o(busy1),
    .port1_rx_data_o(), .port1_rx_valid_o(), .port_c_unconfigured_o(unconf)
  );

  port0_master_model port0_master_model_inst (
    .link_clk_o(link_clk), .select_n_o(sel_n), .mosi_o(mosi), .miso_i(e6_pin)
  );

  // Core clock at 250 MHz.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Records each received port 0 word, and each port 1 data bit at its clock rise.
  always @(posedge core_clk) begin
    if (rx0_valid === 1'b1) begin
      rx_cnt  <= rx_cnt + 8'h01;
      rx_last <= rx0;
    end
  end
  always @(posedge c0_pin) begin
    p1_bits  <= {p1_bits[6:0], c1_pin};
    p1_edges <= p1_edges + 1;
  end

  // Cuts a hung run short.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic test_done();
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // Loads one configuration with a write strobe and lets it reach the pins.
  task automatic apply(input row_t r);
    @(posedge core_clk);
    {gpio_select, gpio_dir, gpio_data, pe_en, pc_en, alt_a, alt_b, tsel, tdrv, m0, m1} <= r.cfg;
    config_write <= 1'b1;
    @(posedge core_clk);
    config_write <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : apply

  // Holds reset through 4 link clocks and 12 more cycles, and checks the reset state of the pins.
  task automatic do_reset();
    @(posedge core_clk);
    reset <= 1'b1;
    port0_master_model_inst.reset_clocks(4);
    repeat (12) @(posedge core_clk);
    #1;
    check({4'h0, oe_n}, 8'h0F);
    check({4'h0, pullup_en}, 8'h0F);
    check({7'h0, unconf}, 8'h00);
    @(posedge core_clk);
    reset <= 1'b0;
  endtask : do_reset

  initial begin
    reset = 1'b1;
    config_write = 1'b0;
    {gpio_select, gpio_dir, gpio_data, pe_en, pc_en, alt_a, alt_b, tsel, tdrv, m0, m1} = 24'h0;
    {tout, tx0, tx1, start, rx_cnt, p1_bits} = {2'h1, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00};
    {failures, compares, cycles, p1_edges} = {32'h0, 32'h0, 32'h0, 32'h0};
    rows = '{'{24'hF5F900, 4'hA, 4'h5, 4'h6},
             '{24'hFAF000, 4'h5, 4'hA, 4'h0},
             '{24'h000F1E, 4'hB, 4'h0, 4'hF},
             '{24'h000F32, 4'hF, 4'h0, 4'hF},
             '{24'h000FFD, 4'h3, 4'h0, 4'hF},
             '{24'h000FC0, 4'hF, 4'h0, 4'hF},
             '{24'h400FF1, 4'h7, 4'h0, 4'hF}};
    do_reset();
    for (i = 0; i < 7; i++) begin
      apply(rows[i]);
      check({4'h0, oe_n}, {4'h0, rows[i].exp_oe});
      check({4'h0, outv & ~oe_n & gpio_select}, {4'h0, rows[i].exp_out});
      check({4'h0, pullup_en}, {4'h0, rows[i].exp_pu});
    end
    // Port 0 slave: a partial frame is dropped, the full word crosses both ways.
    apply(rows[5]);
    tx0 <= 8'h3C;
    rx_cnt = 8'h00;
    check({7'h0, e6_oe_n}, 8'h01);
    port0_master_model_inst.transfer(8'hFF, 3, got);
    repeat (4) @(posedge core_clk);
    port0_master_model_inst.transfer(8'hA5, 8, got);
    repeat (10) @(posedge core_clk);
    #1;
    check(got, 8'h3C);
    check(rx_last, 8'hA5);
    check(rx_cnt, 8'h01);
    check({7'h0, e6_oe_n}, 8'h01);
    // Port 0 master: the data pin stays an input and nothing is received.
    apply(rows[3]);
    port0_master_model_inst.transfer(8'h5A, 8, got);
    repeat (10) @(posedge core_clk);
    #1;
    check(rx_cnt, 8'h01);
    check({7'h0, e6_oe_n}, 8'h01);
    // Port 1 master word on the phase pins.
    apply(rows[4]);
    p1_edges = 0;
    @(posedge core_clk);
    tx1 <= 8'hC3;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    for (k = 0; k < 4 && busy1 !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    for (n = 0; n < 200 && busy1 === 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    check(n[7:0], 8'h40);
    check(p1_bits, 8'hC3);
    check(p1_edges[7:0], 8'h08);
    do_reset();
    test_done();
  end
endmodule : tb
